//--- pcc_config_bank.sv
// module: ahb-lite register bank for output power gating and system clock selection
//
// Function
// - headphone left/right enables, cleared at reset
// - line output left/right enables, cleared at reset
// - speaker mixer left/right enables, default off
// - speaker output left/right enables, default off
// - playback converters: left bit3, right bit2
// - record converters: left bit1, right bit0
// - halve bit divides master clock by two
// - bit 15 selects master clock or loop
// - ratio field 13:10 resets 0011, mode 9:8
// - family 00 ratio codes decode to multiples, 0110 reserved
// - family 01 ratio codes decode to multiples
// - family 10 ratio codes decode, some paired
module pcc_config_bank
    import pcc_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // stage power enables
    output pcc_power_s power,
    // system clock path controls
    output pcc_clock_s clock_cfg,
    // decoded ratio
    output logic [10:0] ratio,
    output logic ratio_reserved
);

    // ------------------------------------------------------------
    // address phase decode
    // ------------------------------------------------------------
    wire aph_go; // a transfer is taken this edge
    wire aph_word_ok; // aligned word inside the 1 KB window
    wire [7:0] aph_idx; // register index of the address phase
    wire aph_read; // read taken this edge

    assign aph_go = hsel & hready & htrans[1];
    assign aph_word_ok = (haddr[31:10] == 22'h000000) & (haddr[1:0] == 2'h0) & (hsize == PCC_HSIZE_WORD);
    assign aph_idx = haddr[9:2];
    assign aph_read = aph_go & ~hwrite;

    // ------------------------------------------------------------
    // data phase state
    // ------------------------------------------------------------
    logic dph_write_r; // data phase of an accepted write pending
    logic [7:0] dph_idx_r; // its register index

    // capture only well formed writes, anything else is dropped
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dph_write_r <= 1'b0;
            dph_idx_r <= 8'h00;
        end else begin
            dph_write_r <= aph_go & hwrite & aph_word_ok;
            dph_idx_r <= aph_idx;
        end
    end

    // ------------------------------------------------------------
    // write strobes, one per register
    // ------------------------------------------------------------
    wire wr_hp; // headphone register written
    wire wr_line; // line output register written
    wire wr_mix; // speaker mixer register written
    wire wr_spk; // speaker output register written
    wire wr_conv; // converter register written
    wire wr_div; // divider register written
    wire wr_rates; // rates register written

    assign wr_hp = dph_write_r & (dph_idx_r == PCC_IDX_HEADPHONE);
    assign wr_line = dph_write_r & (dph_idx_r == PCC_IDX_LINE);
    assign wr_mix = dph_write_r & (dph_idx_r == PCC_IDX_SPK_MIXER);
    assign wr_spk = dph_write_r & (dph_idx_r == PCC_IDX_SPK_OUTPUT);
    assign wr_conv = dph_write_r & (dph_idx_r == PCC_IDX_CONVERTER);
    assign wr_div = dph_write_r & (dph_idx_r == PCC_IDX_MCLK_DIV);
    assign wr_rates = dph_write_r & (dph_idx_r == PCC_IDX_SYS_RATES);

    // ------------------------------------------------------------
    // next register values
    // ------------------------------------------------------------
    pcc_power_s power_r; // stage enables
    pcc_power_s power_nxt;
    pcc_clock_s clock_r; // clock path fields
    pcc_clock_s clock_nxt;

    // headphone pair
    assign power_nxt.left_headphone_enable = wr_hp ? hwdata[PCC_POS_LEFT] : power_r.left_headphone_enable;
    assign power_nxt.right_headphone_enable = wr_hp ? hwdata[PCC_POS_RIGHT] : power_r.right_headphone_enable;
    // line output pair
    assign power_nxt.left_line_output_enable = wr_line ? hwdata[PCC_POS_LEFT] : power_r.left_line_output_enable;
    assign power_nxt.right_line_output_enable =
        wr_line ? hwdata[PCC_POS_RIGHT] : power_r.right_line_output_enable;
    // speaker mixer pair
    assign power_nxt.left_speaker_mixer_enable = wr_mix ? hwdata[PCC_POS_LEFT] : power_r.left_speaker_mixer_enable;
    assign power_nxt.right_speaker_mixer_enable =
        wr_mix ? hwdata[PCC_POS_RIGHT] : power_r.right_speaker_mixer_enable;
    // speaker output pair
    assign power_nxt.left_speaker_output_enable =
        wr_spk ? hwdata[PCC_POS_LEFT] : power_r.left_speaker_output_enable;
    assign power_nxt.right_speaker_output_enable =
        wr_spk ? hwdata[PCC_POS_RIGHT] : power_r.right_speaker_output_enable;
    // converters, four bits in one register
    assign power_nxt.left_playback_converter_enable =
        wr_conv ? hwdata[PCC_POS_DAC_L] : power_r.left_playback_converter_enable;
    assign power_nxt.right_playback_converter_enable =
        wr_conv ? hwdata[PCC_POS_DAC_R] : power_r.right_playback_converter_enable;
    assign power_nxt.left_record_converter_enable =
        wr_conv ? hwdata[PCC_POS_ADC_L] : power_r.left_record_converter_enable;
    assign power_nxt.right_record_converter_enable =
        wr_conv ? hwdata[PCC_POS_ADC_R] : power_r.right_record_converter_enable;
    // clock path fields
    assign clock_nxt.master_clock_halve = wr_div ? hwdata[PCC_POS_HALVE] : clock_r.master_clock_halve;
    assign clock_nxt.system_clock_source_select =
        wr_rates ? hwdata[PCC_POS_SRC_SEL] : clock_r.system_clock_source_select;
    assign clock_nxt.clock_to_rate_ratio =
        wr_rates ? hwdata[PCC_POS_RATIO_LO +: 4] : clock_r.clock_to_rate_ratio;
    assign clock_nxt.clock_family_mode =
        wr_rates ? hwdata[PCC_POS_MODE_LO +: 2] : clock_r.clock_family_mode;

    // ------------------------------------------------------------
    // ratio decode on the next field values
    // ------------------------------------------------------------
    // decoding the next value keeps the ratio in step with the field,
    // at the cost of the decoder sitting on the write data path
    wire [10:0] ratio_nxt; // multiple of fs
    wire reserved_nxt; // code has no multiple

    pcc_ratio_decode u_ratio_decode (
        .rate_code(clock_nxt.clock_to_rate_ratio),
        .family(clock_nxt.clock_family_mode),
        .ratio(ratio_nxt),
        .reserved(reserved_nxt)
    );

    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    logic [10:0] ratio_r; // decoded multiple
    logic ratio_reserved_r; // reserved code flag

    // all enables off, master clock undivided and selected, 256*fs
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            power_r <= '0;
            clock_r.master_clock_halve <= 1'b0;
            clock_r.system_clock_source_select <= 1'b0;
            clock_r.clock_to_rate_ratio <= PCC_RATIO_RST;
            clock_r.clock_family_mode <= PCC_MODE_RST;
            ratio_r <= PCC_RATIO_VAL_RST;
            ratio_reserved_r <= 1'b0;
        end else begin
            power_r <= power_nxt;
            clock_r <= clock_nxt;
            ratio_r <= ratio_nxt;
            // a reserved code is flagged, not blocked: software must avoid it
            ratio_reserved_r <= reserved_nxt;
        end
    end

    // ------------------------------------------------------------
    // read mux, fed from the next values
    // ------------------------------------------------------------
    // using _nxt lets a read that follows a write back to back see
    // the freshly written value with no wait state
    logic [31:0] rd_word; // word for the address phase index

    always_comb begin
        rd_word = 32'h00000000;
        case (aph_idx)
            PCC_IDX_HEADPHONE: begin
                rd_word[PCC_POS_LEFT] = power_nxt.left_headphone_enable;
                rd_word[PCC_POS_RIGHT] = power_nxt.right_headphone_enable;
            end
            PCC_IDX_LINE: begin
                rd_word[PCC_POS_LEFT] = power_nxt.left_line_output_enable;
                rd_word[PCC_POS_RIGHT] = power_nxt.right_line_output_enable;
            end
            PCC_IDX_SPK_MIXER: begin
                rd_word[PCC_POS_LEFT] = power_nxt.left_speaker_mixer_enable;
                rd_word[PCC_POS_RIGHT] = power_nxt.right_speaker_mixer_enable;
            end
            PCC_IDX_SPK_OUTPUT: begin
                rd_word[PCC_POS_LEFT] = power_nxt.left_speaker_output_enable;
                rd_word[PCC_POS_RIGHT] = power_nxt.right_speaker_output_enable;
            end
            PCC_IDX_CONVERTER: begin
                rd_word[PCC_POS_DAC_L] = power_nxt.left_playback_converter_enable;
                rd_word[PCC_POS_DAC_R] = power_nxt.right_playback_converter_enable;
                rd_word[PCC_POS_ADC_L] = power_nxt.left_record_converter_enable;
                rd_word[PCC_POS_ADC_R] = power_nxt.right_record_converter_enable;
            end
            PCC_IDX_MCLK_DIV: begin
                rd_word[PCC_POS_HALVE] = clock_nxt.master_clock_halve;
            end
            PCC_IDX_SYS_RATES: begin
                rd_word[PCC_POS_SRC_SEL] = clock_nxt.system_clock_source_select;
                rd_word[PCC_POS_RATIO_LO +: 4] = clock_nxt.clock_to_rate_ratio;
                rd_word[PCC_POS_MODE_LO +: 2] = clock_nxt.clock_family_mode;
            end
            PCC_IDX_RATIO_STATUS: begin
                rd_word[10:0] = ratio_nxt;
                rd_word[PCC_POS_RSVD_FLAG] = reserved_nxt;
            end
            // unmapped index reads zero
            default: rd_word = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------
    // bus answer registers
    // ------------------------------------------------------------
    logic [31:0] hrdata_r; // read data for the data phase
    logic hreadyout_r; // never stalls after reset
    logic hresp_r; // always okay

    // read data is loaded at the address edge; malformed reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r <= 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hrdata_r <= (aph_read & aph_word_ok) ? rd_word : 32'h00000000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;
    assign power = power_r;
    assign clock_cfg = clock_r;
    assign ratio = ratio_r;
    assign ratio_reserved = ratio_reserved_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    // headphone pair follows the written data one edge after the data phase
    chk_headphone_write: assert property (
        wr_hp |=> (power.left_headphone_enable == $past(hwdata[1])) &&
            (power.right_headphone_enable == $past(hwdata[0])))
        else $error("headphone enables do not match written data");

    // left line enable follows a full write transfer two edges after the address phase
    chk_line_write: assert property (
        (aph_go && hwrite && aph_word_ok && aph_idx == PCC_IDX_LINE) ##1 1'b1 |=>
            (power.left_line_output_enable == $past(hwdata[1])))
        else $error("line output enable missed its write");

    // mixer pair changes only when written
    chk_mixer_stable: assert property (
        !wr_mix |=> $stable({power.left_speaker_mixer_enable, power.right_speaker_mixer_enable}))
        else $error("speaker mixer enables changed without a write");

    // speaker output right bit
    chk_speaker_write: assert property (
        wr_spk |=> power.right_speaker_output_enable == $past(hwdata[0]))
        else $error("speaker output enable does not match written data");

    // converter bit placement
    chk_converter_bits: assert property (
        wr_conv |=> (power.left_playback_converter_enable == $past(hwdata[3])) &&
            (power.right_playback_converter_enable == $past(hwdata[2])))
        else $error("playback converter bits misplaced");

    chk_record_bits: assert property (
        wr_conv |=> (power.left_record_converter_enable == $past(hwdata[1])) &&
            (power.right_record_converter_enable == $past(hwdata[0])))
        else $error("record converter bits misplaced");

    // halve, source select, ratio and mode fields
    chk_halve_bit: assert property (
        wr_div |=> clock_cfg.master_clock_halve == $past(hwdata[0]))
        else $error("master clock halve bit not taken");

    chk_source_bit: assert property (
        wr_rates |=> clock_cfg.system_clock_source_select == $past(hwdata[15]))
        else $error("clock source select not taken from bit 15");

    chk_ratio_field: assert property (
        wr_rates |=> (clock_cfg.clock_to_rate_ratio == $past(hwdata[13:10])) &&
            (clock_cfg.clock_family_mode == $past(hwdata[9:8])))
        else $error("ratio or mode field misplaced");

    // decode checks tie the ratio output to the stored fields
    chk_family256_decode: assert property (
        (clock_cfg.clock_family_mode == 2'h0 && clock_cfg.clock_to_rate_ratio == 4'h8) |-> ratio == 11'h580)
        else $error("family 00 code 1000 is not 1408");

    chk_family272_decode: assert property (
        (clock_cfg.clock_family_mode == 2'h1 && clock_cfg.clock_to_rate_ratio == 4'h9) |-> ratio == 11'h660)
        else $error("family 01 code 1001 is not 1632");

    chk_family250_pairs: assert property (
        (clock_cfg.clock_family_mode == 2'h2 && clock_cfg.clock_to_rate_ratio[3:1] == 3'h0) |-> ratio == 11'h07D)
        else $error("family 10 codes 0000 and 0001 are not 125");

    // zero wait state, okay answer after reset
    chk_bus_answer: assert property (
        aph_read |=> hreadyout && !hresp)
        else $error("slave did not answer with okay and no wait");

endmodule : pcc_config_bank

//--- pcc_config_bank_tb.sv
// testbench: power gating and system clock register bank over ahb-lite
module pcc_config_bank_tb
    import pcc_pkg::*;
;
timeunit 1ns;
timeprecision 1ps;
// ----------------------------------------
// bench signals
// ----------------------------------------
logic hclk = 1'b0;
logic hresetn, hsel, hwrite, hresp, hreadyout, ratio_reserved;
logic [31:0] haddr, hwdata, hrdata;
logic [1:0] htrans;
logic [2:0] hsize;
logic [10:0] ratio;
pcc_power_s power;
pcc_clock_s clock_cfg;
int err_total, n_compared, cyc;
// ratio multiples per code, 0 where the code has none
int r00[10] = '{64, 128, 192, 256, 384, 512, 0, 1024, 1408, 1536};
int r01[10] = '{68, 136, 204, 272, 408, 544, 816, 1088, 1496, 1632};
int r10[10] = '{125, 125, 250, 250, 375, 500, 750, 1000, 1000, 1500};
pcc_config_bank i_pcc_config_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .power(power), .clock_cfg(clock_cfg),
    .ratio(ratio), .ratio_reserved(ratio_reserved));
always #5 hclk = ~hclk;
// hang guard: the whole run needs well under 3000 cycles
always @(posedge hclk) begin
    cyc++;
    if (cyc == 8000) begin
        err_total++;
        print_verdict();
    end
end
task print_verdict();
    if (err_total == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
endtask : print_verdict
task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
        err_total++;
        $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
endtask : chk
// sample just before the edge so the edge's own updates never race the bench
task bus_wait(output logic [31:0] d);
    logic r;
    do begin
        @(negedge hclk);
        r = hreadyout;
        d = hrdata;
        if (r === 1'b1) chk({31'h0, hresp}, 32'h0);
        @(posedge hclk);
    end while (r !== 1'b1);
endtask : bus_wait
// one single word transfer: address phase, then data phase
task bus(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
    logic [31:0] x;
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    hsize <= PCC_HSIZE_WORD;
    bus_wait(x);
    htrans <= 2'h0;
    hwdata <= wd;
    bus_wait(rd);
endtask : bus
task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
    @(negedge hclk);
endtask : wr
task rd_chk(input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    bus(1'b0, a, 32'h0, d);
    chk(d, exp);
endtask : rd_chk
// ----------------------------------------
// scenarios
// ----------------------------------------
task test_reset();
    chk({20'h0, power}, 32'h0);
    chk({24'h0, clock_cfg}, {24'h0, 2'b00, PCC_RATIO_RST, PCC_MODE_RST});
    chk({21'h0, ratio}, 32'h100);
    for (int i = 0; i < 5; i++) rd_chk(32'h38 + 4 * i, 32'h0);
    rd_chk(32'h50, 32'h0);
    rd_chk(32'h54, 32'h0C00);
endtask : test_reset
// left then right of each pair; unused bits must not stick
task test_power();
    logic [11:0] e;
    e = 12'h0;
    for (int i = 0; i < 4; i++) begin
        wr(32'h38 + 4 * i, 32'hFFFE);
        e[11 - 2 * i] = 1'b1;
        chk({20'h0, power}, {20'h0, e});
        rd_chk(32'h38 + 4 * i, 32'h2);
        wr(32'h38 + 4 * i, 32'h1);
        e[11 - 2 * i] = 1'b0;
        e[10 - 2 * i] = 1'b1;
        chk({20'h0, power}, {20'h0, e});
    end
    wr(32'h48, 32'hA);
    chk({28'h0, power[3:0]}, 32'hA);
    wr(32'h48, 32'h5);
    chk({28'h0, power[3:0]}, 32'h5);
    rd_chk(32'h48, 32'h5);
    wr(32'h4C, 32'hFFFF); // unmapped place: nothing may change
    rd_chk(32'h4C, 32'h0);
    chk({20'h0, power}, {20'h0, e[11:4], 4'h5});
endtask : test_power
task test_clock();
    wr(32'h50, 32'h1);
    chk({31'h0, clock_cfg.master_clock_halve}, 32'h1);
    rd_chk(32'h50, 32'h1);
    wr(32'h50, 32'h0);
    chk({31'h0, clock_cfg.master_clock_halve}, 32'h0);
    wr(32'h54, 32'h8C00);
    chk({31'h0, clock_cfg.system_clock_source_select}, 32'h1);
    rd_chk(32'h54, 32'h8C00);
endtask : test_clock
// every legal code of each family, decoded and read back
task test_ratio();
    int e;
    for (int m = 0; m < 3; m++) begin
        for (int c = 0; c < 10; c++) begin
            e = (m == 0) ? r00[c] : (m == 1) ? r01[c] : r10[c];
            wr(32'h54, (c << 10) | (m << 8));
            chk({21'h0, ratio}, e);
            chk({31'h0, ratio_reserved}, {31'h0, e == 0});
            chk({24'h0, clock_cfg}, {24'h0, 2'b00, c[3:0], m[1:0]});
            rd_chk(32'h54, (c << 10) | (m << 8));
            // status word: multiple in the low bits, flag at bit 16
            rd_chk(32'h80, (e == 0) ? 32'h10000 : e);
        end
    end
    // family 11 has no multiples at all
    wr(32'h54, 32'h0300);
    chk({21'h0, ratio}, 32'h0);
    chk({31'h0, ratio_reserved}, 32'h1);
    rd_chk(32'h80, 32'h10000);
endtask : test_ratio
// reset again in mid-run: every field must fall back to its reset value
task test_midrun_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    test_reset();
endtask : test_midrun_reset
initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    hsize = PCC_HSIZE_WORD;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(negedge hclk);
    test_reset();
    test_power();
    test_clock();
    test_ratio();
    test_midrun_reset();
    print_verdict();
end
endmodule : pcc_config_bank_tb

//--- pcc_pkg.sv
// package: register map, field layout, reset values and carriers for the power and clock bank
package pcc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [7:0] PCC_IDX_HEADPHONE = 8'h0E; // headphone_output_power
    localparam logic [7:0] PCC_IDX_LINE = 8'h0F; // line_output_power
    localparam logic [7:0] PCC_IDX_SPK_MIXER = 8'h10; // speaker_mixer_power
    localparam logic [7:0] PCC_IDX_SPK_OUTPUT = 8'h11; // speaker_output_power
    localparam logic [7:0] PCC_IDX_CONVERTER = 8'h12; // converter_power
    localparam logic [7:0] PCC_IDX_MCLK_DIV = 8'h14; // master_clock_divider
    localparam logic [7:0] PCC_IDX_SYS_RATES = 8'h15; // system_clock_rates
    localparam logic [7:0] PCC_IDX_RATIO_STATUS = 8'h20; // decoded ratio, read only

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int PCC_POS_LEFT = 1; // left enable in the pair registers
    localparam int PCC_POS_RIGHT = 0; // right enable in the pair registers
    localparam int PCC_POS_DAC_L = 3;
    localparam int PCC_POS_DAC_R = 2;
    localparam int PCC_POS_ADC_L = 1;
    localparam int PCC_POS_ADC_R = 0;
    localparam int PCC_POS_HALVE = 0;
    localparam int PCC_POS_SRC_SEL = 15;
    localparam int PCC_POS_RATIO_LO = 10; // ratio field is 13:10
    localparam int PCC_POS_MODE_LO = 8; // family mode field is 9:8
    localparam int PCC_POS_RSVD_FLAG = 16; // reserved flag in the status word

    // ------------------------------------------------------------
    // widths, reset values and family mode codes
    // ------------------------------------------------------------
    localparam int PCC_RATIO_W = 11; // holds up to 1632
    localparam logic [3:0] PCC_RATIO_RST = 4'h3; // 256*fs in family 00
    localparam logic [1:0] PCC_MODE_RST = 2'h0;
    localparam logic [1:0] PCC_MODE_256 = 2'h0; // 256*fs related clocks
    localparam logic [1:0] PCC_MODE_272 = 2'h1; // 272*fs related clocks
    localparam logic [1:0] PCC_MODE_250 = 2'h2; // 250*fs related clocks
    localparam logic [10:0] PCC_RATIO_VAL_RST = 11'h100; // 256, decode of the reset field

    // ------------------------------------------------------------
    // ahb-lite codes
    // ------------------------------------------------------------
    localparam logic [2:0] PCC_HSIZE_WORD = 3'h2;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic left_headphone_enable;
        logic right_headphone_enable;
        logic left_line_output_enable;
        logic right_line_output_enable;
        logic left_speaker_mixer_enable;
        logic right_speaker_mixer_enable;
        logic left_speaker_output_enable;
        logic right_speaker_output_enable;
        logic left_playback_converter_enable;
        logic right_playback_converter_enable;
        logic left_record_converter_enable;
        logic right_record_converter_enable;
    } pcc_power_s;

    typedef struct packed {
        logic master_clock_halve;
        logic system_clock_source_select;
        logic [3:0] clock_to_rate_ratio;
        logic [1:0] clock_family_mode;
    } pcc_clock_s;

endpackage : pcc_pkg

//--- pcc_ratio_decode.sv
// module: turns the ratio code and family mode into a clock-to-sample-rate multiple
module pcc_ratio_decode
    import pcc_pkg::*;
(
    // field inputs
    input wire logic [3:0] rate_code,
    input wire logic [1:0] family,
    // decoded outputs
    output logic [10:0] ratio,
    output logic reserved
);

    // ------------------------------------------------------------
    // lookup, zero plus reserved for any code without a multiple
    // ------------------------------------------------------------
    always_comb begin
        ratio = 11'h000;
        reserved = 1'b0;
        case ({family, rate_code})
            // family 00, 256*fs related
            6'h00: ratio = 11'h040; // 64
            6'h01: ratio = 11'h080; // 128
            6'h02: ratio = 11'h0C0; // 192
            6'h03: ratio = 11'h100; // 256
            6'h04: ratio = 11'h180; // 384
            6'h05: ratio = 11'h200; // 512
            6'h07: ratio = 11'h400; // 1024
            6'h08: ratio = 11'h580; // 1408
            6'h09: ratio = 11'h600; // 1536
            // family 01, 272*fs related, low codes follow 17/16 of family 00
            6'h10: ratio = 11'h044; // 68
            6'h11: ratio = 11'h088; // 136
            6'h12: ratio = 11'h0CC; // 204
            6'h13: ratio = 11'h110; // 272
            6'h14: ratio = 11'h198; // 408
            6'h15: ratio = 11'h220; // 544
            6'h16: ratio = 11'h330; // 816
            6'h17: ratio = 11'h440; // 1088
            6'h18: ratio = 11'h5D8; // 1496
            6'h19: ratio = 11'h660; // 1632
            // family 10, 250*fs related, three code pairs share a multiple
            6'h20, 6'h21: ratio = 11'h07D; // 125
            6'h22, 6'h23: ratio = 11'h0FA; // 250
            6'h24: ratio = 11'h177; // 375
            6'h25: ratio = 11'h1F4; // 500
            6'h26: ratio = 11'h2EE; // 750
            6'h27, 6'h28: ratio = 11'h3E8; // 1000
            6'h29: ratio = 11'h5DC; // 1500
            // codes 1010..1111, family 11, unlisted 0110 of family 00
            default: reserved = 1'b1;
        endcase
    end

endmodule : pcc_ratio_decode
